// [rtl/iap_consts.svh]
// constants for the indirect address pointer unit
`ifndef IAP_CONSTS_SVH
`define IAP_CONSTS_SVH
`define IAP_NUM_PTR        3
`define IAP_ADDR_W         12
`define IAP_VIRT_BASE      12'hFE3
`define IAP_VIRT_STRIDE    12'h008
`define IAP_PTR_BASE       12'hFD9
`define IAP_PTR_STRIDE     12'h008
`define IAP_PTR_LOW_OFS    12'h000
`define IAP_PTR_HIGH_OFS   12'h001
`define IAP_PTR_RESET      12'h000
`define IAP_HIGH_BITS      4
`endif

// [rtl/iap_pkg.sv]
// types for the indirect address pointer unit
package iap_pkg;
  typedef enum logic [2:0] {
    IAP_OP_PLUSIDX,
    IAP_OP_PRE_INCREMENT,
    IAP_OP_POST_INCREMENT,
    IAP_OP_POST_DECREMENT,
    IAP_OP_PLAIN,
    IAP_OP_NONE
  } iap_op_e;
  typedef logic [11:0] iap_addr_t;
endpackage : iap_pkg

// [rtl/iap_ptr_math.sv]
// effective address and pointer update arithmetic for one pointer pair
`timescale 1ns/1ps
`default_nettype none
`include "iap_consts.svh"
module iap_ptr_math
  import iap_pkg::*;
(
  // operands
  input  wire logic [7:0]  ptrLow,
  input  wire logic [7:0]  ptrHigh,
  input  wire logic [7:0]  workReg,
  input  wire iap_op_e     op,
  // results
  output logic [11:0]      effAddr,
  output logic [15:0]      nextPtr,
  output logic             ptrUpdate
);
  logic [15:0] ptrFull;
  logic [15:0] ptrInc;
  logic [15:0] ptrDec;
  logic [15:0] ptrIdx;
  // sixteen-bit adds so a low-byte wrap carries into the high byte
  assign ptrFull = {ptrHigh, ptrLow};
  assign ptrInc  = ptrFull + 16'h0001;
  assign ptrDec  = ptrFull - 16'h0001;
  assign ptrIdx  = ptrFull + {{8{workReg[7]}}, workReg};
  // address choice; only the low twelve bits reach memory
  assign effAddr = (op == IAP_OP_PRE_INCREMENT) ? ptrInc[11:0] :
                   (op == IAP_OP_PLUSIDX)       ? ptrIdx[11:0] :
                   ptrFull[11:0];
  assign ptrUpdate = (op == IAP_OP_PRE_INCREMENT) || (op == IAP_OP_POST_INCREMENT) ||
                     (op == IAP_OP_POST_DECREMENT);
  assign nextPtr = (op == IAP_OP_POST_DECREMENT) ? ptrDec : ptrInc;
endmodule : iap_ptr_math
`default_nettype wire

// [rtl/iap_pointer_unit.sv]
// indirect addressing pointer unit with three pointer pairs
// Function
// - each pointer pair has four virtual operands plus the plain one, none indirectly reachable
// - post-decrement addresses with current pointer, then pointer drops by one
// - post-increment addresses with current pointer, then pointer rises by one
// - pre-increment raises pointer first and addresses with the raised value
// - indexed operand address is pointer plus sign-extended working register
// - plain operand addresses with the stored pointer, leaving it unchanged
// - indexed access changes neither pointer nor working register
// - updates act on the whole sixteen-bit pair with low-to-high carry
// - pointer updates never touch arithmetic status flags
// - indirect read landing on a virtual operand returns zero
// - indirect write landing on a virtual operand does nothing
// - writing a pair through its own virtual operand stores value without adjustment; the code lets the other byte take the stepped value
// - pointer bytes are physical registers open to direct access
// - indirect access reaches all other registers normally
`timescale 1ns/1ps
`default_nettype none
`include "iap_consts.svh"
module iap_pointer_unit
  import iap_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // core access port: address already resolved by the core's direct decode
  input  wire logic        accRead,
  input  wire logic        accWrite,
  input  wire logic [11:0] accAddr,
  input  wire logic [7:0]  accWdata,
  input  wire logic [7:0]  workReg,
  // data memory side
  input  wire logic [7:0]  memRdata,
  output logic             memRead,
  output logic             memWrite,
  output logic [11:0]      memAddr,
  output logic [7:0]       memWdata,
  // answer to the core
  output logic [7:0]       accRdata,
  output logic             accHit,
  // pointer view
  output logic [47:0]      ptrView
);
  localparam int NP = `IAP_NUM_PTR;

  // pointer storage, one sixteen-bit pair each
  logic [15:0] ptr_q [NP];
  logic [15:0] ptr_d [NP];
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;

  // which pointer a virtual-operand address belongs to, and which operand
  function automatic logic virtHit(input logic [11:0] a, input int n);
    logic [11:0] base;
    base = 12'(`IAP_VIRT_BASE - n * `IAP_VIRT_STRIDE);
    return (a >= base) && (a <= base + 12'h004);
  endfunction : virtHit

  function automatic iap_op_e virtOp(input logic [11:0] a, input int n);
    logic [11:0] base;
    logic [11:0] ofs;
    base = 12'(`IAP_VIRT_BASE - n * `IAP_VIRT_STRIDE);
    ofs  = a - base;
    case (ofs[2:0])
      3'h0:    return IAP_OP_PLUSIDX;
      3'h1:    return IAP_OP_PRE_INCREMENT;
      3'h2:    return IAP_OP_POST_INCREMENT;
      3'h3:    return IAP_OP_POST_DECREMENT;
      3'h4:    return IAP_OP_PLAIN;
      default: return IAP_OP_NONE;
    endcase
  endfunction : virtOp

  function automatic logic anyVirt(input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    for (int n = 0; n < NP; n++) begin
      hit = hit | virtHit(a, n);
    end
    return hit;
  endfunction : anyVirt

  // pointer-byte address for pair n, low or high
  function automatic logic [11:0] ptrAddr(input int n, input logic hi);
    return 12'(`IAP_PTR_BASE - n * `IAP_PTR_STRIDE + {11'h000, hi});
  endfunction : ptrAddr

  // decode the incoming access to a pointer and an operand
  logic    accValid;
  logic    selHit;
  int      selIdx;
  iap_op_e selOp;
  always_comb begin
    selHit = 1'b0;
    selIdx = 0;
    selOp  = IAP_OP_NONE;
    for (int n = 0; n < NP; n++) begin
      if (virtHit(accAddr, n)) begin
        selHit = 1'b1;
        selIdx = n;
        selOp  = virtOp(accAddr, n);
      end
    end
  end
  assign accValid = (accRead | accWrite) & selHit;

  // arithmetic for the selected pair
  logic [11:0] effAddr;
  logic [15:0] nextPtr;
  logic        ptrUpdate;
  logic [15:0] selPtr;
  assign selPtr = ptr_q[selIdx];
  iap_ptr_math u_math (
    .ptrLow    (selPtr[7:0]),
    .ptrHigh   (selPtr[15:8]),
    .workReg   (workReg),
    .op        (selOp),
    .effAddr   (effAddr),
    .nextPtr   (nextPtr),
    .ptrUpdate (ptrUpdate)
  );

  // target classification of the effective address
  logic tgtVirt;
  logic tgtPtr;
  int   tgtIdx;
  logic tgtHi;
  assign tgtVirt = anyVirt(effAddr);
  always_comb begin
    tgtPtr = 1'b0;
    tgtIdx = 0;
    tgtHi  = 1'b0;
    for (int n = 0; n < NP; n++) begin
      if (effAddr == ptrAddr(n, 1'b0) || effAddr == ptrAddr(n, 1'b1)) begin
        tgtPtr = 1'b1;
        tgtIdx = n;
        tgtHi  = (effAddr == ptrAddr(n, 1'b1));
      end
    end
  end

  // direct access to pointer bytes by address
  logic dirPtr;
  int   dirIdx;
  logic dirHi;
  always_comb begin
    dirPtr = 1'b0;
    dirIdx = 0;
    dirHi  = 1'b0;
    for (int n = 0; n < NP; n++) begin
      if (accAddr == ptrAddr(n, 1'b0) || accAddr == ptrAddr(n, 1'b1)) begin
        dirPtr = 1'b1;
        dirIdx = n;
        dirHi  = (accAddr == ptrAddr(n, 1'b1));
      end
    end
  end

  // memory strobes: virtual targets are blocked, pointer targets served locally
  logic passOn;
  assign passOn   = accValid & ~tgtVirt & ~tgtPtr;
  assign memRead  = passOn & accRead;
  assign memWrite = passOn & accWrite;
  assign memAddr  = effAddr;
  assign memWdata = accWdata;
  assign accHit   = accValid | ((accRead | accWrite) & dirPtr);

  // next pointer values; a write into a pointer byte wins over that byte's adjustment
  always_comb begin
    for (int n = 0; n < NP; n++) begin
      ptr_d[n] = ptr_q[n];
    end
    if (accValid && ptrUpdate) begin
      ptr_d[selIdx] = nextPtr;
    end
    if (accValid && accWrite && tgtPtr) begin
      // indirect write into a pointer byte lands without any step
      if (tgtHi) begin
        ptr_d[tgtIdx][15:8] = accWdata;
      end else begin
        ptr_d[tgtIdx][7:0] = accWdata;
      end
    end
    if (accWrite && dirPtr) begin
      if (dirHi) begin
        ptr_d[dirIdx][15:8] = accWdata;
      end else begin
        ptr_d[dirIdx][7:0] = accWdata;
      end
    end
  end

  // read data: zero for virtual targets, pointer bytes local, else memory
  logic [15:0] tgtPtrVal;
  logic [15:0] dirPtrVal;
  assign tgtPtrVal = ptr_q[tgtIdx];
  assign dirPtrVal = ptr_q[dirIdx];
  always_comb begin
    rdata_d = 8'h00;
    if (accRead && dirPtr) begin
      rdata_d = dirHi ? dirPtrVal[15:8] : dirPtrVal[7:0];
    end else if (accValid && accRead) begin
      if (tgtVirt) begin
        rdata_d = 8'h00;
      end else if (tgtPtr) begin
        rdata_d = tgtHi ? tgtPtrVal[15:8] : tgtPtrVal[7:0];
      end else begin
        rdata_d = memRdata;
      end
    end
  end

  // state registers; no status flags live here by design
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int n = 0; n < NP; n++) begin
        ptr_q[n] <= 16'h0000;
      end
      rdata_q <= 8'h00;
    end else begin
      for (int n = 0; n < NP; n++) begin
        ptr_q[n] <= ptr_d[n];
      end
      rdata_q <= rdata_d;
    end
  end

  assign accRdata = rdata_q;
  assign ptrView  = {ptr_q[2], ptr_q[1], ptr_q[0]};
endmodule : iap_pointer_unit
`default_nettype wire

// [test/iap_mem_model.sv]
// data memory model standing behind the unit
`timescale 1ns/1ps
`default_nettype none
module iap_mem_model (
  // strobe and address
  input  wire logic        memRead,
  input  wire logic [11:0] memAddr,
  // answer
  output logic [7:0]       memRdata
);
  // unselected memory shows the inverse so stale data cannot pass
  assign memRdata = memRead ? memAddr[7:0] ^ {2{memAddr[11:8]}} : ~memAddr[7:0];
endmodule : iap_mem_model
`default_nettype wire

// [test/iap_pointer_unit_asserts.sv]
// concurrent checks for the pointer unit
`timescale 1ns/1ps
`default_nettype none
module iap_pointer_unit_asserts (
  // clock, reset, core side
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        accRead,
  input wire logic        accWrite,
  input wire logic [11:0] accAddr,
  input wire logic [7:0]  accWdata,
  input wire logic [7:0]  workReg,
  // memory side and answers
  input wire logic [7:0]  memRdata,
  input wire logic        memRead,
  input wire logic        memWrite,
  input wire logic [11:0] memAddr,
  input wire logic [7:0]  accRdata,
  input wire logic [47:0] ptrView
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // pair 0 only when it points into plain data memory
  wire [11:0] p0 = ptrView[11:0];
  wire rd0 = (accRead || accWrite) && p0[11:8] != 4'h0 && !p0[11];
  sequence stepUp;
    ##1 ptrView[15:0] == $past(ptrView[15:0]) + 16'h0001;
  endsequence
  plain_keep_a: assert property (rd0 && accAddr == 12'hFE7 |-> memAddr == p0 ##1 $stable(ptrView))
    else $error("plain operand wrong");
  post_dec_a: assert property (rd0 && accAddr == 12'hFE6 |-> memAddr == p0
    ##1 ptrView[15:0] == $past(ptrView[15:0]) - 16'h0001)
    else $error("post-decrement wrong");
  post_inc_a: assert property (rd0 && accAddr == 12'hFE5 |-> memAddr == p0 ##0 stepUp)
    else $error("post-increment wrong");
  pre_inc_a: assert property (rd0 && accAddr == 12'hFE4 |-> memAddr == p0 + 12'h001 ##0 stepUp)
    else $error("pre-increment wrong");
  index_addr_a: assert property (rd0 && accAddr == 12'hFE3 |->
    memAddr == p0 + {{4{workReg[7]}}, workReg} ##1 $stable(ptrView)) else $error("indexed wrong");
  virt_read_a: assert property (accRead && accAddr == 12'hFE7 && p0 == 12'hFDF |->
    !memRead ##1 accRdata == 8'h00) else $error("virtual read not zero");
  virt_write_a: assert property (accWrite && accAddr == 12'hFE7 && p0 == 12'hFDF |->
    !memWrite ##1 $stable(ptrView)) else $error("virtual write not dropped");
  own_write_a: assert property (accWrite && accAddr == 12'hFE6 && p0 == 12'hFD9 |=>
    ptrView[15:0] == {$past(ptrView[15:8]), $past(accWdata)}) else $error("own write adjusted");
  direct_high_a: assert property (accWrite && accAddr == 12'hFDA |=>
    ptrView[15:8] == $past(accWdata)) else $error("direct write lost");
  read_data_a: assert property (accRead && memRead |=> accRdata == $past(memRdata))
    else $error("read answer wrong");
endmodule : iap_pointer_unit_asserts
bind iap_pointer_unit iap_pointer_unit_asserts chk (.clk, .rst_b, .accRead, .accWrite,
  .accAddr, .accWdata, .workReg, .memRdata, .memRead, .memWrite, .memAddr, .accRdata, .ptrView);
`default_nettype wire

// [test/tb.sv]
// self-checking bench for the pointer unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rst_b, accRead, accWrite, memRead, memWrite, accHit, rdQ;
  logic [11:0] accAddr, memAddr;
  logic [7:0] accWdata, workReg, memRdata, memWdata, accRdata;
  logic [47:0] ptrView, pv;
  logic [7:0] expQ[$];
  int n_fail = 0, cmp_count = 0, cyc = 0;
  iap_pointer_unit uut (.clk, .rst_b, .accRead, .accWrite, .accAddr, .accWdata, .workReg,
    .memRdata, .memRead, .memWrite, .memAddr, .memWdata, .accRdata, .accHit, .ptrView);
  iap_mem_model mem (.memRead, .memAddr, .memRdata);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [47:0] seen, exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // hang guard, the run needs under a hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      n_fail++;
      end_sim();
    end
  end
  // read answers land one edge after the request
  always @(posedge clk) rdQ <= accRead;
  always @(negedge clk) if (rdQ) chk(accRdata, expQ.pop_front(), "accRdata");
  // addresses the unit claims: five operands and two pointer bytes per pair
  function automatic logic claimed(input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    for (int n = 0; n < 3; n++) begin
      hit |= (a >= 12'hFE3 - 12'(8 * n)) && (a <= 12'hFE7 - 12'(8 * n));
      hit |= (a == 12'hFD9 - 12'(8 * n)) || (a == 12'hFDA - 12'(8 * n));
    end
    return hit;
  endfunction : claimed
  // one access at the falling edge; ix adds the signed offset
  task automatic acc(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     input logic hit, ix, input logic [11:0] ea);
    @(negedge clk);
    chk(ptrView, pv, "ptrView");
    {accRead, accWrite, accAddr, accWdata, workReg} = {!wr, wr, a, d, 8'($urandom)};
    if (ix) ea = ea + {{4{workReg[7]}}, workReg};
    #1;
    chk(wr ? memWrite : memRead, hit, "strobe");
    chk(accHit, claimed(a), "accHit");
    if (hit) chk(memAddr, ea, "memAddr");
    if (wr && hit) chk(memWdata, d, "memWdata");
    if (!wr) expQ.push_back(hit ? ea[7:0] ^ {2{ea[11:8]}} : 8'h00);
  endtask : acc
  task automatic setp(input int n, input logic [15:0] v);
    acc(1'b1, 12'hFD9 - 12'(8 * n), v[7:0], 1'b0, 1'b0, 12'h000);
    pv[16*n +: 8] = v[7:0];
    acc(1'b1, 12'hFDA - 12'(8 * n), v[15:8], 1'b0, 1'b0, 12'h000);
    pv[16*n+8 +: 8] = v[15:8];
  endtask : setp
  initial begin
    logic [15:0] p;
    void'($urandom(32'h442052cd));
    {rst_b, accRead, accWrite, accAddr, accWdata, workReg, pv} = '0;
    repeat (3) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    // every operand of every pair, random pointer and direction
    for (int n = 0; n < 3; n++) begin
      for (int k = 0; k < 5; k++) begin
        p = 16'($urandom) & 16'hF7FF | 16'h0100;
        setp(n, p);
        if (k == 3) p++;
        acc(1'($urandom), 12'hFE7 - 12'(8 * n + k), 8'($urandom), 1'b1, k == 4, p[11:0]);
        if (k == 1) p--;
        if (k == 2) p++;
        pv[16*n +: 16] = p;
      end
    end
    // low byte rollover both ways, upper nibble ignored
    setp(0, 16'h32FF);
    acc(1'b0, 12'hFE5, 8'h00, 1'b1, 1'b0, 12'h2FF);
    pv[15:0] = 16'h3300;
    acc(1'b0, 12'hFE6, 8'h00, 1'b1, 1'b0, 12'h300);
    pv[15:0] = 16'h32FF;
    // pointer aimed at another pair's operand, then at its own low byte
    setp(0, 16'h0FDF);
    acc(1'b0, 12'hFE7, 8'h00, 1'b0, 1'b0, 12'h000);
    acc(1'b1, 12'hFE7, 8'h77, 1'b0, 1'b0, 12'h000);
    setp(0, 16'h0FD9);
    acc(1'b1, 12'hFE6, 8'hA5, 1'b0, 1'b0, 12'h000);
    pv[7:0] = 8'hA5;
    // direct read of a pointer byte, then indirect read and write into another pair
    acc(1'b0, 12'hFDA, 8'h00, 1'b0, 1'b0, 12'h000);
    expQ[$] = pv[15:8];
    setp(0, 16'h0FD1);
    acc(1'b0, 12'hFE7, 8'h00, 1'b0, 1'b0, 12'h000);
    expQ[$] = pv[23:16];
    setp(0, 16'h0FD2);
    acc(1'b1, 12'hFE5, 8'h3C, 1'b0, 1'b0, 12'h000);
    pv[31:24] = 8'h3C;
    pv[15:0] = 16'h0FD3;
    acc(1'b0, 12'h000, 8'h00, 1'b0, 1'b0, 12'h000);
    @(negedge clk) {accRead, accWrite} = 2'b00;
    // mid-run reset clears every pair; the first access comes a cycle after release
    @(negedge clk) rst_b = 1'b0;
    pv = '0;
    @(negedge clk) rst_b = 1'b1;
    acc(1'b0, 12'hFE5, 8'h00, 1'b1, 1'b0, 12'h000);
    pv[15:0] = 16'h0001;
    @(negedge clk) {accRead, accWrite} = 2'b00;
    chk(ptrView, pv, "ptrView");
    repeat (2) @(negedge clk);
    end_sim();
  end
endmodule : tb
`default_nettype wire
